// ==== common/arqc_pkg.sv ====
// Shared constants of the ADC request queue control block
package arqc_pkg;
	// ----------------------------------------
	// Widths and depths
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CH_W   = 3;
	localparam int N_CH   = 8;
	localparam int QDEPTH = 16;
	localparam int LVL_W  = 5;
	localparam int FLAG_W = 10;
	localparam int CNT_W  = 8;
	localparam logic [LVL_W-1:0] QFULL_LVL = 5'h10;
	localparam logic [CH_W-1:0]  SCAN_LAST = 3'h7;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CON   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CMD   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_QREQ  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_AP    = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_CHIN  = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_SERVICE_NODE_POINTERS  = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_MASK  = 8'h24;
	localparam logic [2:0]        CHANNEL_CONTROL_SEL = 3'h2;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CON_QEN     = 0;
	localparam int CON_TEST    = 1;
	localparam int CON_SCAN_LO = 2;
	localparam int CON_WARN_LO = 4;
	localparam int CON_WARN_EN = 8;
	localparam int CON_CIR     = 9;
	localparam int CMD_QUEUE_ENABLE_CLEAR    = 0;
	localparam int CMD_QUEUE_ENABLE_SET    = 1;
	localparam int CMD_QRS     = 2;
	localparam int AP_QUEUE    = 0;
	localparam int AP_INJ      = 1;
	localparam int STAT_FULL   = 5;
	localparam int STAT_BUSY   = 6;
	localparam int STAT_SRC_LO = 8;
	localparam int FLAG_SCAN   = 8;
	localparam int FLAG_WARN   = 9;

	// ----------------------------------------
	// Codes and reset values
	// ----------------------------------------
	localparam logic [2:0] SRC_NONE  = 3'h0;
	localparam logic [2:0] SRC_SCAN  = 3'h1;
	localparam logic [2:0] SRC_INJ   = 3'h2;
	localparam logic [2:0] SRC_QUEUE = 3'h6;
	localparam logic [1:0] SCAN_OFF    = 2'h0;
	localparam logic [1:0] SCAN_SINGLE = 2'h1;
	localparam logic [LVL_W-1:0] LVL_RST = 5'h00;
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ      = 100;
	localparam int CONV_TIME_NS = 500;
	localparam logic [CNT_W-1:0] CONV_CYC = CNT_W'((CONV_TIME_NS * CLK_MHZ + 999) / 1000);
endpackage

// ==== hdl/arqc_queue.sv ====
// Sixteen stage conversion request queue
`timescale 1ns/10ps
module arqc_queue
	import arqc_pkg::*;
(
	input  wire logic                       i_clk,
	input  wire logic                       i_srst,
	input  wire logic                       i_push,
	input  wire logic [arqc_pkg::CH_W-1:0]  i_chan,
	input  wire logic                       i_pop,
	input  wire logic                       i_clear,
	output logic      [arqc_pkg::LVL_W-1:0] o_level,
	output logic                            o_full,
	output logic      [arqc_pkg::CH_W-1:0]  o_head
);
	typedef struct packed {
		logic [QDEPTH-1:0][CH_W-1:0] ent;
		logic [LVL_W-1:0]            lvl;
	} arqc_q_t;

	arqc_q_t cur_ff;
	arqc_q_t nxt_q;

	always_comb begin
		nxt_q = cur_ff;
		if (i_clear) begin
			nxt_q.lvl = LVL_RST;
		end else begin
			if (i_pop && cur_ff.lvl != LVL_RST) begin
				for (int i = 0; i < QDEPTH - 1; i++) begin
					nxt_q.ent[i] = cur_ff.ent[i+1];
				end
				nxt_q.lvl = LVL_W'(cur_ff.lvl - 5'h01);
			end
			if (i_push && nxt_q.lvl != QFULL_LVL) begin
				nxt_q.ent[nxt_q.lvl[3:0]] = i_chan;
				nxt_q.lvl = LVL_W'(nxt_q.lvl + 5'h01);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst)
			cur_ff <= '0;
		else
			cur_ff <= nxt_q;
	end

	assign o_level = cur_ff.lvl;
	assign o_full  = (cur_ff.lvl == QFULL_LVL);
	assign o_head  = cur_ff.ent[0];
endmodule

// ==== hdl/arqc_conv_timer.sv ====
// Conversion duration counter
`timescale 1ns/10ps
module arqc_conv_timer
	import arqc_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_srst,
	input  wire logic i_start,
	input  wire logic i_cancel,
	output logic      o_busy,
	output logic      o_done
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             done;
	} arqc_tm_t;

	arqc_tm_t cur_ff;
	arqc_tm_t nxt_t;

	always_comb begin
		nxt_t      = cur_ff;
		nxt_t.done = 1'b0;
		if (i_start)
			nxt_t.cnt = CONV_CYC;
		else if (i_cancel)
			nxt_t.cnt = CNT_RST;
		else if (cur_ff.cnt != CNT_RST) begin
			nxt_t.cnt  = CNT_W'(cur_ff.cnt - 8'h01);
			nxt_t.done = (cur_ff.cnt == 8'h01);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst)
			cur_ff <= '0;
		else
			cur_ff <= nxt_t;
	end

	assign o_busy = (cur_ff.cnt != CNT_RST);
	assign o_done = cur_ff.done;
endmodule

// ==== hdl/arqc_ctrl.sv ====
// Request queue and source arbitration control of the converter
`timescale 1ns/10ps
module arqc_ctrl
	import arqc_pkg::*;
(
	input  wire logic                        I_CLOCK,
	input  wire logic                        I_SRST,
	input  wire logic [arqc_pkg::ADDR_W-1:0] I_ADDR,
	input  wire logic [arqc_pkg::DATA_W-1:0] I_WDATA,
	input  wire logic                        I_WR,
	input  wire logic                        I_RD,
	output logic      [arqc_pkg::DATA_W-1:0] O_RDATA,
	output logic                             O_IRQ,
	output logic                             O_CONV_START,
	output logic      [arqc_pkg::CH_W-1:0]   O_CONV_CHAN,
	output logic                             O_BUSY
);
	import arqc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic              q_en;
		logic              test_mode;
		logic [1:0]        scan_mode;
		logic [3:0]        warn_lvl;
		logic              warn_en;
		logic              cir_en;
		logic              ap_queue;
		logic              ap_inj;
		logic [CH_W-1:0]   inj_chan;
		logic              scan_ie;
		logic [N_CH-1:0]   chan_ie;
		logic [FLAG_W-1:0] flags;
		logic [FLAG_W-1:0] mask;
		logic [2:0]        run_src;
		logic [CH_W-1:0]   run_chan;
		logic              bk_valid;
		logic [2:0]        bk_src;
		logic [CH_W-1:0]   bk_chan;
		logic [CH_W-1:0]   scan_idx;
		logic              start;
		logic [DATA_W-1:0] rdata;
	} arqc_state_t;

	arqc_state_t cur_ff;
	arqc_state_t nxt_s;

	logic [LVL_W-1:0] q_lvl;
	logic             q_full;
	logic [CH_W-1:0]  q_head;
	logic             q_push;
	logic             q_pop;
	logic             q_clear;
	logic             q_accept;
	logic             t_busy;
	logic             t_done;
	logic             t_start;
	logic             t_cancel;

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	function automatic logic wr_hit(input logic [ADDR_W-1:0] off);
		return I_WR && (I_ADDR == off);
	endfunction

	function automatic logic [LVL_W-1:0] warn_thr(input logic [3:0] setting);
		if (setting == 4'h0)
			return 5'h00;
		return LVL_W'({1'b0, setting} + 5'h01);
	endfunction

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	arqc_queue u_queue (
		.i_clk   (I_CLOCK),
		.i_srst  (I_SRST),
		.i_push  (q_accept),
		.i_chan  (I_WDATA[CH_W-1:0]),
		.i_pop   (q_pop),
		.i_clear (q_clear),
		.o_level (q_lvl),
		.o_full  (q_full),
		.o_head  (q_head)
	);

	arqc_conv_timer u_timer (
		.i_clk    (I_CLOCK),
		.i_srst   (I_SRST),
		.i_start  (t_start),
		.i_cancel (t_cancel),
		.o_busy   (t_busy),
		.o_done   (t_done)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_s       = cur_ff;
		nxt_s.start = 1'b0;
		nxt_s.rdata = '0;
		q_pop       = 1'b0;
		t_start     = 1'b0;
		t_cancel    = 1'b0;
		q_clear     = wr_hit(OFF_CMD) && I_WDATA[CMD_QRS];
		q_push      = wr_hit(OFF_QREQ);

		// Register writes
		if (wr_hit(OFF_CON)) begin
			nxt_s.q_en      = I_WDATA[CON_QEN];
			nxt_s.test_mode = I_WDATA[CON_TEST];
			nxt_s.scan_mode = I_WDATA[CON_SCAN_LO+:2];
			nxt_s.warn_lvl  = I_WDATA[CON_WARN_LO+:4];
			nxt_s.warn_en   = I_WDATA[CON_WARN_EN];
			nxt_s.cir_en    = I_WDATA[CON_CIR];
			nxt_s.scan_idx  = '0;
		end
		if (wr_hit(OFF_CMD)) begin
			if (I_WDATA[CMD_QUEUE_ENABLE_CLEAR])
				nxt_s.q_en = 1'b0;
			if (I_WDATA[CMD_QUEUE_ENABLE_SET])
				nxt_s.q_en = 1'b1;
		end
		if (q_clear)
			nxt_s.ap_queue = 1'b0;
		if (wr_hit(OFF_AP)) begin
			nxt_s.ap_queue = cur_ff.ap_queue & I_WDATA[AP_QUEUE];
			nxt_s.ap_inj   = cur_ff.ap_inj & I_WDATA[AP_INJ];
		end
		if (wr_hit(OFF_CHIN)) begin
			nxt_s.inj_chan = I_WDATA[CH_W-1:0];
			nxt_s.ap_inj   = 1'b1;
		end
		if (wr_hit(OFF_SERVICE_NODE_POINTERS))
			nxt_s.scan_ie = I_WDATA[0];
		if (wr_hit(OFF_MASK))
			nxt_s.mask = I_WDATA[FLAG_W-1:0];
		if (I_WR && I_ADDR[7:5] == CHANNEL_CONTROL_SEL)
			nxt_s.chan_ie[I_ADDR[4:2]] = I_WDATA[0];
		if (wr_hit(OFF_FLAGS)) begin
			if (cur_ff.test_mode)
				nxt_s.flags = cur_ff.flags | I_WDATA[FLAG_W-1:0];
			else
				nxt_s.flags = cur_ff.flags & ~I_WDATA[FLAG_W-1:0];
		end

		// Completion of the running conversion
		if (t_done) begin
			if (cur_ff.chan_ie[cur_ff.run_chan])
				nxt_s.flags[cur_ff.run_chan] = 1'b1;
			if (cur_ff.run_src == SRC_SCAN && cur_ff.run_chan == SCAN_LAST) begin
				if (cur_ff.scan_ie)
					nxt_s.flags[FLAG_SCAN] = 1'b1;
				if (cur_ff.scan_mode == SCAN_SINGLE)
					nxt_s.scan_mode = SCAN_OFF;
			end
		end

		// Arbitration: injection, repeat, queue, autoscan
		if (t_busy) begin
			if (nxt_s.cir_en && nxt_s.ap_inj && !cur_ff.bk_valid && cur_ff.run_src != SRC_INJ) begin
				t_cancel       = 1'b1;
				nxt_s.bk_valid = 1'b1;
				nxt_s.bk_src   = cur_ff.run_src;
				nxt_s.bk_chan  = cur_ff.run_chan;
				t_start        = 1'b1;
				nxt_s.run_src  = SRC_INJ;
				nxt_s.run_chan = nxt_s.inj_chan;
				nxt_s.ap_inj   = 1'b0;
			end
		end else if (cur_ff.bk_valid && !nxt_s.ap_inj) begin
			t_start        = 1'b1;
			nxt_s.bk_valid = 1'b0;
			nxt_s.run_src  = cur_ff.bk_src;
			nxt_s.run_chan = cur_ff.bk_chan;
		end else if (nxt_s.ap_inj) begin
			t_start        = 1'b1;
			nxt_s.run_src  = SRC_INJ;
			nxt_s.run_chan = nxt_s.inj_chan;
			nxt_s.ap_inj   = 1'b0;
		end else if (nxt_s.q_en && nxt_s.ap_queue && q_lvl != LVL_RST && !q_clear) begin
			t_start        = 1'b1;
			q_pop          = 1'b1;
			nxt_s.run_src  = SRC_QUEUE;
			nxt_s.run_chan = q_head;
			if (q_lvl == 5'h01)
				nxt_s.ap_queue = 1'b0;
			if (nxt_s.warn_en && LVL_W'(q_lvl - 5'h01) == warn_thr(nxt_s.warn_lvl))
				nxt_s.flags[FLAG_WARN] = 1'b1;
		end else if (nxt_s.scan_mode != SCAN_OFF) begin
			t_start        = 1'b1;
			nxt_s.run_src  = SRC_SCAN;
			nxt_s.run_chan = nxt_s.scan_idx;
			nxt_s.scan_idx = CH_W'(nxt_s.scan_idx + 3'h1);
		end
		nxt_s.start = t_start;

		// Append a request, refused only when every stage is taken
		q_accept = q_push && (q_lvl != QFULL_LVL || q_pop);
		if (q_accept)
			nxt_s.ap_queue = 1'b1;

		// Read data, one cycle after the strobe
		if (I_RD) begin
			if (I_ADDR[7:5] == CHANNEL_CONTROL_SEL)
				nxt_s.rdata = DATA_W'(cur_ff.chan_ie[I_ADDR[4:2]]);
			else begin
				unique case (I_ADDR)
					OFF_CON: begin
						nxt_s.rdata[CON_QEN]          = cur_ff.q_en;
						nxt_s.rdata[CON_TEST]         = cur_ff.test_mode;
						nxt_s.rdata[CON_SCAN_LO+:2]   = cur_ff.scan_mode;
						nxt_s.rdata[CON_WARN_LO+:4]   = cur_ff.warn_lvl;
						nxt_s.rdata[CON_WARN_EN]      = cur_ff.warn_en;
						nxt_s.rdata[CON_CIR]          = cur_ff.cir_en;
					end
					OFF_STAT: begin
						nxt_s.rdata[LVL_W-1:0]        = q_lvl;
						nxt_s.rdata[STAT_FULL]        = q_full;
						nxt_s.rdata[STAT_BUSY]        = t_busy;
						nxt_s.rdata[STAT_SRC_LO+:3]   = t_busy ? cur_ff.run_src : SRC_NONE;
					end
					OFF_AP: begin
						nxt_s.rdata[AP_QUEUE]         = cur_ff.ap_queue;
						nxt_s.rdata[AP_INJ]           = cur_ff.ap_inj;
					end
					OFF_CHIN:  nxt_s.rdata[CH_W-1:0]   = cur_ff.inj_chan;
					OFF_SERVICE_NODE_POINTERS:  nxt_s.rdata[0]          = cur_ff.scan_ie;
					OFF_FLAGS: nxt_s.rdata[FLAG_W-1:0] = cur_ff.flags;
					OFF_MASK:  nxt_s.rdata[FLAG_W-1:0] = cur_ff.mask;
					default:   nxt_s.rdata             = '0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST)
			cur_ff <= '0;
		else
			cur_ff <= nxt_s;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign O_RDATA      = cur_ff.rdata;
	assign O_IRQ        = |(cur_ff.flags & cur_ff.mask);
	assign O_CONV_START = cur_ff.start;
	assign O_CONV_CHAN  = cur_ff.run_chan;
	assign O_BUSY       = t_busy;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (I_SRST);

	sequence s_queue_start;
		q_pop && t_start;
	endsequence

	sequence s_queue_running;
		t_busy && cur_ff.run_src == SRC_QUEUE && O_CONV_START;
	endsequence

	sequence s_reset_cmd;
		I_WR && I_ADDR == OFF_CMD && I_WDATA[CMD_QRS];
	endsequence

	AST_QUEUE_RESET: assert property (s_reset_cmd |=> q_lvl == LVL_RST && !q_full)
		else $error("queue reset left entries valid");

	AST_ENABLE_CLEAR: assert property (
		I_WR && I_ADDR == OFF_CMD && I_WDATA[CMD_QUEUE_ENABLE_CLEAR] && !I_WDATA[CMD_QUEUE_ENABLE_SET]
		|=> !cur_ff.q_en && !q_pop)
		else $error("queue kept running after enable clear");

	AST_FULL_FLAG: assert property (q_full == (q_lvl == QFULL_LVL) && q_lvl <= QFULL_LVL)
		else $error("full flag and level pointer disagree");

	AST_POP_ENABLED: assert property (s_queue_start |-> nxt_s.q_en ##1 O_CONV_CHAN == $past(q_head))
		else $error("queue conversion without enable or wrong stage 0 channel");

	AST_APPEND: assert property (
		q_push && !q_pop && q_lvl < QFULL_LVL && !q_clear |=> q_lvl == $past(q_lvl) + 5'h01)
		else $error("accepted request not appended");

	AST_POP_COUNT: assert property (q_pop && !q_accept |=> q_lvl == $past(q_lvl) - 5'h01)
		else $error("level pointer not decremented on start");

	AST_WARN_ZERO: assert property (
		q_pop && nxt_s.warn_en && nxt_s.warn_lvl == 4'h0 && q_lvl == 5'h01
		|=> cur_ff.flags[FLAG_WARN])
		else $error("warning at level zero not raised");

	AST_BUSY_CODE: assert property (s_queue_start |=> s_queue_running ##1 t_busy[*8])
		else $error("queue conversion not shown busy with source code");

	AST_INJ_CLEAR: assert property (
		I_WR && I_ADDR == OFF_AP && !I_WDATA[AP_INJ]
		|=> q_lvl == LVL_W'($past(q_lvl) - {4'h0, $past(q_pop)}))
		else $error("inject participation clear touched the queue");

	AST_BACKUP_KEEP: assert property (
		wr_hit(OFF_AP) && !I_WDATA[AP_QUEUE] && cur_ff.bk_valid && t_busy
		|=> cur_ff.bk_valid && q_lvl == $past(q_lvl))
		else $error("queue participation clear dropped a held entry");

	AST_TEST_SET: assert property (
		I_WR && I_ADDR == OFF_FLAGS && cur_ff.test_mode && (I_WDATA[FLAG_W-1:0] & cur_ff.mask) != '0
		|=> O_IRQ)
		else $error("test mode flag write raised no interrupt");

	AST_SCAN_CLEAR: assert property (
		I_WR && I_ADDR == OFF_CON && I_WDATA[CON_SCAN_LO+:2] == SCAN_OFF && !t_done
		|=> cur_ff.flags[N_CH-1:0] == $past(cur_ff.flags[N_CH-1:0]))
		else $error("clearing scan mode raised channel requests");

	AST_NO_SCAN_ON_INJ: assert property (
		t_done && cur_ff.run_src == SRC_INJ && !wr_hit(OFF_FLAGS) |=> $stable(cur_ff.flags[FLAG_SCAN]))
		else $error("scan request raised after injected conversion");
endmodule

// ==== sim/tb_adc_request_queue_control.sv ====
// Self-checking testbench of the ADC request queue control block
`timescale 1ns/10ps
module tb_adc_request_queue_control;
	import arqc_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic              clk;
	logic              srst;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr;
	logic              rd;
	logic [DATA_W-1:0] rdata;
	logic              irq;
	logic              conv_start;
	logic [CH_W-1:0]   conv_chan;
	logic              busy;
	logic [DATA_W-1:0] d;
	int                errors;
	int                checks;

	arqc_ctrl u_dut (
		.I_CLOCK      (clk),
		.I_SRST       (srst),
		.I_ADDR       (addr),
		.I_WDATA      (wdata),
		.I_WR         (wr),
		.I_RD         (rd),
		.O_RDATA      (rdata),
		.O_IRQ        (irq),
		.O_CONV_START (conv_start),
		.O_CONV_CHAN  (conv_chan),
		.O_BUSY       (busy)
	);

	initial begin
		clk = 1'b0;
	end
	always #5 clk = ~clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic wait_start(input logic [CH_W-1:0] ch);
		for (int n = 0; n < 200; n++) begin
			@(negedge clk);
			if (conv_start === 1'b1) break;
		end
		chk(32'(conv_start), 32'h00000001);
		chk(32'(conv_chan), 32'(ch));
	endtask

	task automatic wait_idle();
		for (int n = 0; n < 200; n++) begin
			@(posedge clk);
			#1;
			if (busy === 1'b0) break;
		end
		chk(32'(busy), 32'h00000000);
	endtask

	task automatic finish_test();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd_reg(OFF_CON, d);
		chk(d, 32'h00000000);
		rd_reg(OFF_STAT, d);
		chk(d, 32'h00000000);
		rd_reg(OFF_FLAGS, d);
		chk(d, 32'h00000000);
		rd_reg(8'h30, d);
		chk(d, 32'h00000000);
		chk(32'(irq), 32'h00000000);
	endtask

	task automatic t_fill();
		for (int i = 0; i < 16; i++) begin
			wr_reg(OFF_QREQ, 32'(i % 8));
		end
		rd_reg(OFF_STAT, d);
		chk(d, 32'h00000030);
		wr_reg(OFF_QREQ, 32'h00000001);
		rd_reg(OFF_STAT, d);
		chk(d, 32'h00000030);
		wr_reg(OFF_CMD, 32'h00000004);
		rd_reg(OFF_STAT, d);
		chk(d, 32'h00000000);
		wr_reg(OFF_CON, 32'h00000001);
		repeat (20) @(posedge clk);
		#1;
		chk(32'(busy), 32'h00000000);
		wr_reg(OFF_CON, 32'h00000000);
	endtask

	task automatic t_run();
		wr_reg(OFF_QREQ, 32'h00000003);
		wr_reg(OFF_QREQ, 32'h00000005);
		wr_reg(OFF_CON, 32'h00000001);
		wait_start(3'h3);
		rd_reg(OFF_STAT, d);
		chk(d, 32'h00000641);
		wr_reg(OFF_QREQ, 32'h00000007);
		rd_reg(OFF_STAT, d);
		chk(d, 32'h00000642);
		wait_start(3'h5);
		wr_reg(OFF_CMD, 32'h00000001);
		wait_idle();
		repeat (60) @(posedge clk);
		rd_reg(OFF_STAT, d);
		chk(d, 32'h00000001);
		wr_reg(OFF_CMD, 32'h00000002);
		wait_start(3'h7);
		wait_idle();
		rd_reg(OFF_STAT, d);
		chk(d, 32'h00000000);
	endtask

	task automatic t_warn();
		wr_reg(OFF_CON, 32'h00000110);
		wr_reg(OFF_MASK, 32'h00000200);
		for (int i = 0; i < 4; i++) begin
			wr_reg(OFF_QREQ, 32'h00000001);
		end
		wr_reg(OFF_CON, 32'h00000111);
		wait_start(3'h1);
		rd_reg(OFF_FLAGS, d);
		chk(d & 32'h00000200, 32'h00000000);
		chk(32'(irq), 32'h00000000);
		wait_start(3'h1);
		rd_reg(OFF_FLAGS, d);
		chk(d & 32'h00000200, 32'h00000200);
		chk(32'(irq), 32'h00000001);
		wr_reg(OFF_FLAGS, 32'h00000200);
		#1;
		chk(32'(irq), 32'h00000000);
		wr_reg(OFF_CMD, 32'h00000004);
		wait_idle();
		wr_reg(OFF_CON, 32'h00000100);
		wr_reg(OFF_QREQ, 32'h00000002);
		wr_reg(OFF_CON, 32'h00000101);
		wait_start(3'h2);
		rd_reg(OFF_FLAGS, d);
		chk(d & 32'h00000200, 32'h00000200);
		chk(32'(irq), 32'h00000001);
		wr_reg(OFF_FLAGS, 32'h00000200);
		wr_reg(OFF_CON, 32'h00000000);
		wait_idle();
	endtask

	task automatic t_test_mode();
		wr_reg(OFF_FLAGS, 32'h000003FF);
		wr_reg(OFF_CON, 32'h00000002);
		wr_reg(OFF_MASK, 32'h00000001);
		wr_reg(OFF_FLAGS, 32'h00000001);
		#1;
		chk(32'(irq), 32'h00000001);
		wr_reg(OFF_MASK, 32'h00000000);
		#1;
		chk(32'(irq), 32'h00000000);
		wr_reg(OFF_CON, 32'h00000000);
		wr_reg(OFF_FLAGS, 32'h00000001);
		rd_reg(OFF_FLAGS, d);
		chk(d & 32'h00000001, 32'h00000000);
	endtask

	task automatic t_inject();
		wr_reg(OFF_QREQ, 32'h00000004);
		wr_reg(OFF_QREQ, 32'h00000006);
		wr_reg(OFF_CON, 32'h00000001);
		wait_start(3'h4);
		wr_reg(OFF_CHIN, 32'h00000005);
		wr_reg(OFF_AP, 32'h00000001);
		rd_reg(OFF_STAT, d);
		chk(d & 32'h0000001F, 32'h00000001);
		rd_reg(OFF_AP, d);
		chk(d & 32'h00000003, 32'h00000001);
		wait_start(3'h6);
		wr_reg(OFF_QREQ, 32'h00000002);
		wr_reg(OFF_CON, 32'h00000201);
		wr_reg(OFF_CHIN, 32'h00000005);
		wait_start(3'h5);
		wr_reg(OFF_AP, 32'h00000000);
		rd_reg(OFF_STAT, d);
		chk(d, 32'h00000241);
		wait_start(3'h6);
		wait_idle();
		rd_reg(OFF_STAT, d);
		chk(d, 32'h00000001);
		wr_reg(OFF_CMD, 32'h00000004);
		wr_reg(OFF_CON, 32'h00000000);
	endtask

	task automatic t_cir();
		wr_reg(8'h5C, 32'h00000001);
		wr_reg(OFF_SERVICE_NODE_POINTERS, 32'h00000001);
		wr_reg(OFF_FLAGS, 32'h000003FF);
		wr_reg(OFF_CON, 32'h00000204);
		for (int c = 0; c < 8; c++) begin
			wait_start(CH_W'(c));
		end
		wr_reg(OFF_CHIN, 32'h00000005);
		wait_start(3'h5);
		wait_start(3'h7);
		rd_reg(OFF_FLAGS, d);
		chk(d, 32'h00000000);
		wait_idle();
		rd_reg(OFF_FLAGS, d);
		chk(d & 32'h00000080, 32'h00000080);
		chk(d & 32'h00000100, 32'h00000100);
		rd_reg(OFF_STAT, d);
		chk(d, 32'h00000000);
		wr_reg(OFF_FLAGS, 32'h000003FF);
		wr_reg(OFF_CON, 32'h00000000);
	endtask

	task automatic t_scan();
		wr_reg(OFF_FLAGS, 32'h000003FF);
		wr_reg(OFF_CON, 32'h00000004);
		wr_reg(OFF_CON, 32'h00000000);
		repeat (80) @(posedge clk);
		rd_reg(OFF_FLAGS, d);
		chk(d & 32'h000001FE, 32'h00000000);
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		errors = 0;
		checks = 0;
		srst = 1'b1;
		addr = 8'h00;
		wdata = 32'h00000000;
		wr = 1'b0;
		rd = 1'b0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_fill();
		t_run();
		t_warn();
		t_test_mode();
		t_inject();
		t_scan();
		t_cir();
		finish_test();
	end

	initial begin
		#100000;
		errors++;
		finish_test();
	end
endmodule
